/* File: common/pgsel_defines.svh */
`ifndef PGSEL_DEFINES_SVH
`define PGSEL_DEFINES_SVH

// Register indices; byte address is four times the index
`define PGSEL_PWR_IDX        16'hF051
`define PGSEL_SEL_IDX0       16'hF100
`define PGSEL_SEL_IDX_LAST   16'hF107
`define PGSEL_SEL_STEP       16'h0001

// Reset values
`define PGSEL_PWR_RESET      16'h0000
`define PGSEL_SEL_RESET      16'h0000

// Power-enable bit positions
`define PGSEL_BIT_MIC_B      4
`define PGSEL_BIT_MIC_A      3
`define PGSEL_BIT_SPDIF_TX   2
`define PGSEL_BIT_SPDIF_RX   1
`define PGSEL_BIT_AUX_ADC    0

// Selector field positions
`define PGSEL_KIND_LSB       0
`define PGSEL_KIND_MSB       2
`define PGSEL_PAIR_LSB       3
`define PGSEL_PAIR_MSB       7

// Source kind encodings
`define PGSEL_KIND_UNUSED    3'h0
`define PGSEL_KIND_SERIAL    3'h1
`define PGSEL_KIND_CORE      3'h2
`define PGSEL_KIND_SPDIF     3'h3
`define PGSEL_KIND_MIC01     3'h4
`define PGSEL_KIND_MIC23     3'h5

// Highest legal serial pair index
`define PGSEL_PAIR_MAX       5'h17

`endif

/* File: common/pgsel_pkg.sv */
package pgsel_pkg;

  // Power enables in register bit order, bit 0 last
  typedef struct packed {
    logic mic_pair_b_enable;
    logic mic_pair_a_enable;
    logic spdif_transmit_enable;
    logic spdif_receive_enable;
    logic aux_converter_enable;
  } pgsel_pwr_t;

  // One resampler source selector, bits [7:0]
  typedef struct packed {
    logic [4:0] serial_pair_index;
    logic [2:0] resampler_source_kind;
  } pgsel_sel_t;

  // Bus phase tracking
  typedef enum logic [0:0] {
    PGSEL_BUS_IDLE,
    PGSEL_BUS_ACCESS
  } pgsel_bus_t;

endpackage : pgsel_pkg

/* File: common/pgsel_if.sv */
interface pgsel_if #(
  parameter int MIC_W = 24,
  parameter int ADC_W = 10,
  parameter int ADC_N = 6
);
  import pgsel_pkg::*;

  pgsel_pwr_t                    pwr;        // Power enables
  logic [3:0][MIC_W-1:0]         mic_raw;    // Live microphone words
  logic [3:0][MIC_W-1:0]         mic_held;   // Gated microphone words
  logic [ADC_N-1:0][ADC_W-1:0]   adc_raw;    // Live converter results
  logic [ADC_N-1:0][ADC_W-1:0]   adc_held;   // Gated converter results
  logic                          tx_raw;     // Encoder output
  logic                          tx_pin;     // Transmit pin level
  logic                          rx_pin;     // Receive pin level
  logic                          rx_stream;  // Stream into recovery
  logic                          rx_run;     // Recovery running

  modport ctrl (
    output pwr, mic_raw, adc_raw, tx_raw, rx_pin,
    input  mic_held, adc_held, tx_pin, rx_stream, rx_run
  );

  modport gate (
    input  pwr, mic_raw, adc_raw, tx_raw, rx_pin,
    output mic_held, adc_held, tx_pin, rx_stream, rx_run
  );

endinterface : pgsel_if

/* File: logic/pgsel_gate.sv */
`include "pgsel_defines.svh"

module pgsel_gate #(
  parameter int MIC_W = 24,
  parameter int ADC_W = 10,
  parameter int ADC_N = 6
) (
  input  wire logic pclk,        // System clock
  input  wire logic presetn,     // Async reset, active low
  pgsel_if.gate     gif          // Enables in, gated data out
);
  import pgsel_pkg::*;

  typedef struct packed {
    logic [3:0][MIC_W-1:0]       mic;
    logic [ADC_N-1:0][ADC_W-1:0] adc;
    logic                        tx;
    logic                        rx_stream;
    logic                        rx_run;
  } pgsel_gate_st_t;

  pgsel_gate_st_t st_q;
  pgsel_gate_st_t st_d;

  // Each function follows its input only while enabled
  always_comb begin
    st_d = st_q;
    if (gif.pwr.mic_pair_a_enable) begin
      st_d.mic[0] = gif.mic_raw[0];
      st_d.mic[1] = gif.mic_raw[1];
    end
    if (gif.pwr.mic_pair_b_enable) begin
      st_d.mic[2] = gif.mic_raw[2];
      st_d.mic[3] = gif.mic_raw[3];
    end
    // Pin forced low, no clock edges leak out while off
    st_d.tx = gif.pwr.spdif_transmit_enable & gif.tx_raw;
    // Recovery sees a quiet line and stops until re-enabled
    st_d.rx_run    = gif.pwr.spdif_receive_enable;
    st_d.rx_stream = gif.pwr.spdif_receive_enable & gif.rx_pin;
    if (gif.pwr.aux_converter_enable) begin
      st_d.adc = gif.adc_raw;
    end
  end

  // Held values survive a disable, cleared only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign gif.mic_held  = st_q.mic;
  assign gif.adc_held  = st_q.adc;
  assign gif.tx_pin    = st_q.tx;
  assign gif.rx_stream = st_q.rx_stream;
  assign gif.rx_run    = st_q.rx_run;

endmodule : pgsel_gate

/* File: logic/pgsel_top.sv */
`include "pgsel_defines.svh"

module pgsel_top #(
  parameter int MIC_W = 24,   // Microphone word width
  parameter int ADC_W = 10,   // Converter result width
  parameter int ADC_N = 6,    // Number of converter channels
  parameter int N_SEL = 8     // Number of stereo resamplers
) (
  // Clock and reset
  input  wire logic                        pclk,                   // Bus clock
  input  wire logic                        presetn,                // Async reset, low
  // APB slave, zero wait states
  input  wire logic                        psel,                   // APB select
  input  wire logic                        penable,                // APB enable
  input  wire logic                        pwrite,                 // APB direction
  input  wire logic [17:0]                 paddr,                  // APB byte address
  input  wire logic [31:0]                 pwdata,                 // APB write data
  input  wire logic [3:0]                  pstrb,                  // APB byte strobes
  output logic      [31:0]                 prdata,                 // APB read data
  output logic                             pready,                 // APB ready
  output logic                             pslverr,                // APB error
  // Microphone words, held while their pair is off
  input  wire logic [3:0][MIC_W-1:0]       mic_data_in,            // Live mic words
  output logic      [3:0][MIC_W-1:0]       mic_data_out,           // Gated mic words
  // S/PDIF lines
  input  wire logic                        spdif_tx_data_in,       // Encoder output
  output logic                             spdif_tx_pin,           // Transmit pin
  input  wire logic                        spdif_rx_pin,           // Receive pin
  output logic                             spdif_rx_stream,        // Stream to recovery
  output logic                             spdif_rx_recover_run,   // Recovery running
  // Auxiliary converter results
  input  wire logic [ADC_N-1:0][ADC_W-1:0] adc_data_in,            // Live results
  output logic      [ADC_N-1:0][ADC_W-1:0] adc_data_out,           // Held results
  // Power enables, straight from the register
  output logic                             mic_pair_b_enable,      // Mic 2/3 on
  output logic                             mic_pair_a_enable,      // Mic 0/1 on
  output logic                             spdif_transmit_enable,  // Transmitter on
  output logic                             spdif_receive_enable,   // Receiver on
  output logic                             aux_converter_enable,   // Converters on
  // Resampler routes, one entry per stereo pair
  output logic      [N_SEL-1:0][2:0]       route_kind,             // Decoded source kind
  output logic      [N_SEL-1:0][5:0]       route_first_chan,       // Left channel number
  output logic      [N_SEL-1:0]            route_live              // Source usable now
);
  import pgsel_pkg::*;

  typedef struct packed {
    // Register port handshake
    pgsel_bus_t                bus;
    // Software-visible registers
    pgsel_pwr_t                pwr;
    pgsel_sel_t [N_SEL-1:0]    sel;
    // Answer to the current transfer
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    // Decoded routes, one cycle behind the selectors
    logic [N_SEL-1:0][2:0]     kind;
    logic [N_SEL-1:0][5:0]     first;
    logic [N_SEL-1:0]          live;
  } pgsel_top_st_t;

  // Result of the address decode
  typedef struct packed {
    logic       hit_pwr;
    logic       hit_sel;
    logic [7:0] sel_idx;
  } pgsel_hit_t;

  // Registered state and its next value
  pgsel_top_st_t st_q;
  pgsel_top_st_t st_d;
  pgsel_hit_t    hit;
  // Bus phase strobes
  logic          setup_seen;   // Setup cycle on the bus
  logic          write_go;     // Access that may store

  // Enables in, gated data out of the gating module
  pgsel_if #(.MIC_W(MIC_W), .ADC_W(ADC_W), .ADC_N(ADC_N)) gif ();

  // Word index decode; misaligned byte addresses never hit
  // Decoded once per cycle and shared by the read and write paths
  function automatic pgsel_hit_t pgsel_decode(input logic [17:0] addr);
    pgsel_hit_t h;
    logic [15:0] idx;
    h   = '0;
    idx = addr[17:2];
    // Byte lanes 1 to 3 of a word never select a register
    if (addr[1:0] == 2'h0) begin
      h.hit_pwr = (idx == `PGSEL_PWR_IDX);
      h.hit_sel = (idx >= `PGSEL_SEL_IDX0) &&
                  (idx < `PGSEL_SEL_IDX0 + 16'(N_SEL) * `PGSEL_SEL_STEP);
      h.sel_idx = 8'(idx - `PGSEL_SEL_IDX0);
    end
    return h;
  endfunction : pgsel_decode

  // Selector kind decode; reserved encodings and pairs fall back to unused
  function automatic logic [2:0] pgsel_kind(input pgsel_sel_t s);
    logic [2:0] k;
    k = s.resampler_source_kind;
    case (k)
      `PGSEL_KIND_SERIAL: begin
        // Indices past the last pair name no existing channels,
        // so they are refused rather than wrapped
        if (s.serial_pair_index > `PGSEL_PAIR_MAX) begin
          k = `PGSEL_KIND_UNUSED;
        end
      end
      `PGSEL_KIND_CORE,
      `PGSEL_KIND_SPDIF,
      `PGSEL_KIND_MIC01,
      `PGSEL_KIND_MIC23: begin
        k = s.resampler_source_kind;
      end
      default: begin
        k = `PGSEL_KIND_UNUSED;
      end
    endcase
    return k;
  endfunction : pgsel_kind

  // Left channel of the stereo pair that feeds one resampler
  function automatic logic [5:0] pgsel_first(input pgsel_sel_t s, input logic [2:0] k,
                                             input logic [5:0] own);
    logic [5:0] c;
    c = 6'h00;
    case (k)
      `PGSEL_KIND_SERIAL: begin
        c = {s.serial_pair_index, 1'b0};
      end
      `PGSEL_KIND_CORE: begin
        // Core outputs carry no pair field; own pair is used
        c = own;
      end
      `PGSEL_KIND_SPDIF: begin
        // Receiver channels 0 and 1
        c = 6'h00;
      end
      `PGSEL_KIND_MIC01: begin
        c = 6'h00;
      end
      `PGSEL_KIND_MIC23: begin
        // Second microphone pair starts at channel 2
        c = 6'h02;
      end
      default: begin
        c = 6'h00;
      end
    endcase
    return c;
  endfunction : pgsel_first

  // Read value of the addressed register, upper bits zero
  function automatic logic [31:0] pgsel_read(input pgsel_hit_t h, input pgsel_pwr_t p,
                                             input pgsel_sel_t [N_SEL-1:0] s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (h.hit_pwr) begin
      v[`PGSEL_BIT_MIC_B]    = p.mic_pair_b_enable;
      v[`PGSEL_BIT_MIC_A]    = p.mic_pair_a_enable;
      v[`PGSEL_BIT_SPDIF_TX] = p.spdif_transmit_enable;
      v[`PGSEL_BIT_SPDIF_RX] = p.spdif_receive_enable;
      v[`PGSEL_BIT_AUX_ADC]  = p.aux_converter_enable;
    end else if (h.hit_sel) begin
      v[`PGSEL_PAIR_MSB:`PGSEL_PAIR_LSB] = s[h.sel_idx].serial_pair_index;
      v[`PGSEL_KIND_MSB:`PGSEL_KIND_LSB] = s[h.sel_idx].resampler_source_kind;
    end
    return v;
  endfunction : pgsel_read

  // Whether a decoded source can deliver samples under the present enables
  // Trade-off: lags an enable change by one cycle, like the other routes
  function automatic logic pgsel_live(input logic [2:0] k, input pgsel_pwr_t p);
    logic l;
    l = 1'b0;
    case (k)
      `PGSEL_KIND_SERIAL,
      `PGSEL_KIND_CORE: begin
        l = 1'b1;
      end
      `PGSEL_KIND_SPDIF: begin
        l = p.spdif_receive_enable;
      end
      `PGSEL_KIND_MIC01: begin
        l = p.mic_pair_a_enable;
      end
      `PGSEL_KIND_MIC23: begin
        l = p.mic_pair_b_enable;
      end
      default: begin
        // Unused and reserved kinds never carry samples
        l = 1'b0;
      end
    endcase
    return l;
  endfunction : pgsel_live

  assign hit = pgsel_decode(paddr);

  // Phase strobes; a store needs our own ready and no error
  assign setup_seen = psel && !penable;
  assign write_go   = psel && penable && st_q.pready && pwrite &&
                      !st_q.pslverr && pstrb[0];

  // Bus slave, register writes and route decode
  // pready rises one cycle after setup and stands one cycle; a store
  // lands at the edge closing the access, routes follow a cycle later.
  // Back-to-back transfers need no idle cycle between them.
  always_comb begin
    st_d         = st_q;
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    case (st_q.bus)
      PGSEL_BUS_IDLE: begin
        // Setup phase: answer is prepared so access ends at once
        if (setup_seen) begin
          st_d.bus     = PGSEL_BUS_ACCESS;
          st_d.pready  = 1'b1;
          st_d.pslverr = !(hit.hit_pwr || hit.hit_sel);
          // Writes read back zero; reads capture the register now
          if (pwrite) begin
            st_d.prdata = 32'h0000_0000;
          end else begin
            st_d.prdata = pgsel_read(hit, st_q.pwr, st_q.sel);
          end
        end
      end
      PGSEL_BUS_ACCESS: begin
        // Access always ends here: zero wait states
        st_d.bus = PGSEL_BUS_IDLE;
        if (write_go) begin
          // Only the low lane carries fields; reserved bits are dropped
          if (hit.hit_pwr) begin
            st_d.pwr.mic_pair_b_enable     = pwdata[`PGSEL_BIT_MIC_B];
            st_d.pwr.mic_pair_a_enable     = pwdata[`PGSEL_BIT_MIC_A];
            st_d.pwr.spdif_transmit_enable = pwdata[`PGSEL_BIT_SPDIF_TX];
            st_d.pwr.spdif_receive_enable  = pwdata[`PGSEL_BIT_SPDIF_RX];
            st_d.pwr.aux_converter_enable  = pwdata[`PGSEL_BIT_AUX_ADC];
          end else if (hit.hit_sel) begin
            st_d.sel[hit.sel_idx].serial_pair_index =
              pwdata[`PGSEL_PAIR_MSB:`PGSEL_PAIR_LSB];
            st_d.sel[hit.sel_idx].resampler_source_kind =
              pwdata[`PGSEL_KIND_MSB:`PGSEL_KIND_LSB];
          end
        end
      end
      default: begin
        // Unreachable with a one-bit state; falls back to idle
        st_d.bus = PGSEL_BUS_IDLE;
      end
    endcase
    // One route per resampler; mic and receiver sources are live only when powered
    // Kind is decoded first; channel and liveness use the decoded kind
    for (int n = 0; n < N_SEL; n++) begin
      st_d.kind[n]  = pgsel_kind(st_q.sel[n]);
      st_d.first[n] = pgsel_first(st_q.sel[n], st_d.kind[n], 6'(2 * n));
      st_d.live[n]  = pgsel_live(st_d.kind[n], st_q.pwr);
    end
  end

  // All enables and selectors start at zero, so everything starts off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Field by field, so reset values come from one place
      st_q.bus     <= PGSEL_BUS_IDLE;
      st_q.pready  <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.prdata  <= 32'h0000_0000;
      st_q.pwr     <= 5'(`PGSEL_PWR_RESET);
      for (int n = 0; n < N_SEL; n++) begin
        st_q.sel[n] <= 8'(`PGSEL_SEL_RESET);
      end
      st_q.kind    <= '0;
      st_q.first   <= '0;
      st_q.live    <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Gating of the powered functions lives in its own module
  // Its outputs are flip-flops, so the top outputs stay registered
  pgsel_gate #(
    .MIC_W (MIC_W),
    .ADC_W (ADC_W),
    .ADC_N (ADC_N)
  ) u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .gif     (gif.gate)
  );

  // Enables and live data into the gating module
  assign gif.pwr     = st_q.pwr;
  assign gif.mic_raw = mic_data_in;
  assign gif.adc_raw = adc_data_in;
  assign gif.tx_raw  = spdif_tx_data_in;
  assign gif.rx_pin  = spdif_rx_pin;

  // Outputs, all straight from flip-flops
  // pready and pslverr stand one cycle; prdata holds until the next setup, which loads zero for a write
  assign prdata                = st_q.prdata;
  assign pready                = st_q.pready;
  assign pslverr               = st_q.pslverr;
  // Gated data from the gating module
  assign mic_data_out          = gif.mic_held;
  assign adc_data_out          = gif.adc_held;
  assign spdif_tx_pin          = gif.tx_pin;
  assign spdif_rx_stream       = gif.rx_stream;
  assign spdif_rx_recover_run  = gif.rx_run;
  // Power enables and decoded routes
  assign mic_pair_b_enable     = st_q.pwr.mic_pair_b_enable;
  assign mic_pair_a_enable     = st_q.pwr.mic_pair_a_enable;
  assign spdif_transmit_enable = st_q.pwr.spdif_transmit_enable;
  assign spdif_receive_enable  = st_q.pwr.spdif_receive_enable;
  assign aux_converter_enable  = st_q.pwr.aux_converter_enable;
  assign route_kind            = st_q.kind;
  assign route_first_chan      = st_q.first;
  assign route_live            = st_q.live;

endmodule : pgsel_top

/* File: testbench/pgsel_top_props.sv */
module pgsel_chk #(
  parameter int MIC_W = 24,
  parameter int ADC_W = 10,
  parameter int ADC_N = 6
) (
  input wire logic                        pclk,                  // Clock
  input wire logic                        presetn,               // Reset, low
  input wire logic                        psel,                  // Select
  input wire logic                        penable,               // Enable
  input wire logic                        pwrite,                // Direction
  input wire logic [17:0]                 paddr,                 // Address
  input wire logic [31:0]                 pwdata,                // Write data
  input wire logic [3:0]                  pstrb,                 // Strobes
  input wire logic                        pready,                // Ready
  input wire logic                        pslverr,               // Error
  input wire logic [3:0][MIC_W-1:0]       mic_data_in,           // Live mic
  input wire logic [3:0][MIC_W-1:0]       mic_data_out,          // Gated mic
  input wire logic                        spdif_tx_pin,          // Tx pin
  input wire logic                        spdif_rx_recover_run,  // Recovery on
  input wire logic [ADC_N-1:0][ADC_W-1:0] adc_data_in,           // Live results
  input wire logic [ADC_N-1:0][ADC_W-1:0] adc_data_out,          // Held results
  input wire logic                        mic_pair_b_enable,     // Mic 2/3 on
  input wire logic                        mic_pair_a_enable,     // Mic 0/1 on
  input wire logic                        spdif_transmit_enable, // Tx on
  input wire logic                        spdif_receive_enable,  // Rx on
  input wire logic                        aux_converter_enable   // Converters on
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no zero-wait ready");
  property p_pwr_wr;
    psel && penable && pready && pwrite && paddr == 18'h3C144 && pstrb[0] |=>
      {mic_pair_b_enable, mic_pair_a_enable, spdif_transmit_enable, spdif_receive_enable,
       aux_converter_enable} == $past(pwdata[4:0]);
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("enables differ from write");
  // Index F108 lies past the last selector
  property p_err; psel && penable && paddr == 18'h3C420 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("past-end access not refused");
  property p_tx; !spdif_transmit_enable |=> !spdif_tx_pin; endproperty
  a_tx: assert property (p_tx) else $error("tx pin not low while off");
  property p_rx; 1'h1 |=> spdif_rx_recover_run == $past(spdif_receive_enable); endproperty
  a_rx: assert property (p_rx) else $error("recovery run mismatch");
  property p_adc_hold; !aux_converter_enable |=> $stable(adc_data_out); endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("converter output moved");
  property p_adc_trk; aux_converter_enable |=> adc_data_out == $past(adc_data_in); endproperty
  a_adc_trk: assert property (p_adc_trk) else $error("converter not tracking");
  property p_mic_b; !mic_pair_b_enable |=> $stable(mic_data_out[3:2]); endproperty
  a_mic_b: assert property (p_mic_b) else $error("mic 2/3 not frozen");
  property p_mic_a;
    mic_pair_a_enable |=> mic_data_out[1:0] == $past(mic_data_in[1:0]);
  endproperty
  a_mic_a: assert property (p_mic_a) else $error("mic 0/1 not tracking");
endmodule : pgsel_chk

bind pgsel_top pgsel_chk #(.MIC_W(MIC_W), .ADC_W(ADC_W), .ADC_N(ADC_N)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .mic_data_in(mic_data_in), .mic_data_out(mic_data_out), .spdif_tx_pin(spdif_tx_pin),
  .spdif_rx_recover_run(spdif_rx_recover_run), .adc_data_in(adc_data_in),
  .adc_data_out(adc_data_out), .mic_pair_b_enable(mic_pair_b_enable),
  .mic_pair_a_enable(mic_pair_a_enable), .spdif_transmit_enable(spdif_transmit_enable),
  .spdif_receive_enable(spdif_receive_enable), .aux_converter_enable(aux_converter_enable));

/* File: testbench/tb_pgsel_top.sv */
module tb_pgsel_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pgsel_pkg::*;
  localparam logic [95:0] M0 = 96'h111111222222333333444444;
  localparam logic [95:0] M1 = 96'hAAAAAABBBBBBCCCCCCDDDDDD;
  localparam logic [59:0] A0 = 60'h123456789ABCDEF;
  localparam logic [59:0] A1 = 60'hFEDCBA987654321;
  logic             pclk = 1'h0;
  logic             presetn = 1'h0;
  logic             psel = 1'h0;
  logic             penable = 1'h0;
  logic             pwrite = 1'h0;
  logic [17:0]      paddr = 18'h0;
  logic [31:0]      pwdata = 32'h0;
  logic [3:0]       pstrb = 4'h0;
  logic [3:0][23:0] mic_in = 96'h0;
  logic [5:0][9:0]  adc_in = 60'h0;
  logic             tx_in = 1'h0;
  logic             rx_pin = 1'h0;
  logic [31:0]      prdata, rd;
  logic             pready, pslverr, er, tx_pin, rx_stream, rx_run;
  logic [3:0][23:0] mic_out;
  logic [5:0][9:0]  adc_out;
  wire  [4:0]       en;
  logic [7:0][2:0]  r_kind;
  logic [7:0][5:0]  r_chan;
  logic [7:0]       r_live;
  logic [2:0]       kind, ek;
  logic [4:0]       idx;
  logic [5:0]       ch;
  int               fail_count = 0;
  int               samples_checked = 0;

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  pgsel_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mic_data_in(mic_in), .mic_data_out(mic_out),
    .spdif_tx_data_in(tx_in), .spdif_tx_pin(tx_pin), .spdif_rx_pin(rx_pin),
    .spdif_rx_stream(rx_stream), .spdif_rx_recover_run(rx_run), .adc_data_in(adc_in),
    .adc_data_out(adc_out), .mic_pair_b_enable(en[4]), .mic_pair_a_enable(en[3]),
    .spdif_transmit_enable(en[2]), .spdif_receive_enable(en[1]),
    .aux_converter_enable(en[0]), .route_kind(r_kind), .route_first_chan(r_chan),
    .route_live(r_live));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One transfer; an idle edge after it keeps psel from toggling twice in a step
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      fail_count++;
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask : apb

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 18'h3C144, 32'h0, 4'hF);
    check("pwr reset", rd, 96'h0);
    for (int n = 0; n < 8; n++) begin
      apb(1'h0, 18'h3C400 + 18'(4 * n), 32'h0, 4'hF);
      check("sel reset", rd, 96'h0);
    end
    $display("test reset done");
    mic_in <= M0;
    adc_in <= A0;
    tx_in <= 1'h1;
    rx_pin <= 1'h1;
    repeat (3) @(posedge pclk);
    check("mic off", mic_out, 96'h0);
    check("adc off", adc_out, 96'h0);
    check("tx off", tx_pin, 96'h0);
    check("rx off", {rx_stream, rx_run}, 96'h0);
    apb(1'h1, 18'h3C144, 32'hFFFFFFFF, 4'hF);
    apb(1'h0, 18'h3C144, 32'h0, 4'hF);
    check("pwr reserved", rd, 96'h1F);
    repeat (3) @(posedge pclk);
    check("enables", en, 96'h1F);
    check("mic on", mic_out, M0);
    check("adc on", adc_out, A0);
    check("tx on", tx_pin, 96'h1);
    check("rx on", {rx_stream, rx_run}, 96'h3);
    // Cleared strobe must leave the register alone
    apb(1'h1, 18'h3C144, 32'h0, 4'h0);
    apb(1'h1, 18'h3C144, 32'h8, 4'h1);
    mic_in <= M1;
    adc_in <= A1;
    repeat (3) @(posedge pclk);
    check("mic a live", mic_out[1:0], M1[47:0]);
    check("mic b frozen", mic_out[3:2], M0[95:48]);
    check("adc held", adc_out, A0);
    check("tx stopped", tx_pin, 96'h0);
    check("rx halted", {rx_stream, rx_run}, 96'h0);
    $display("test gating done");
    // Mic 2/3 and receiver on, mic 0/1 off: shapes the live flags
    apb(1'h1, 18'h3C144, 32'h12, 4'h1);
    for (int n = 0; n < 8; n++) begin
      apb(1'h1, 18'h3C400 + 18'(4 * n), 32'hA500 | (n == 7 ? 32'h6 : n == 6 ? 32'hB9 :
          32'(n) | 32'(3 * n) << 3), 4'h1);
      check("sel write err", er, 96'h0);
    end
    repeat (2) @(posedge pclk);
    for (int n = 0; n < 8; n++) begin
      kind = n == 7 ? 3'h6 : n == 6 ? 3'h1 : 3'(n);
      idx = n == 7 ? 5'h00 : n == 6 ? 5'h17 : 5'(3 * n);
      ek = kind > 3'h5 ? 3'h0 : kind;
      ch = ek == 3'h1 ? 6'(2 * idx) : ek == 3'h2 ? 6'(2 * n) : ek == 3'h5 ? 6'h2 : 6'h0;
      apb(1'h0, 18'h3C400 + 18'(4 * n), 32'h0, 4'hF);
      check("sel read", rd, {idx, kind});
      check("route kind", r_kind[n], ek);
      check("route chan", r_chan[n], ch);
    end
    check("route live", r_live, 96'h6E);
    // Pair index past the last serial pair must decode as unused
    apb(1'h1, 18'h3C400, 32'hC1, 4'h1);
    repeat (2) @(posedge pclk);
    check("bad pair kind", r_kind[0], 96'h0);
    check("bad pair live", r_live[0], 96'h0);
    $display("test selectors done");
    apb(1'h0, 18'h3C420, 32'h0, 4'hF);
    check("past end", {er, rd}, 96'h100000000);
    apb(1'h1, 18'h3C148, 32'h1, 4'hF);
    check("unmapped", er, 96'h1);
    apb(1'h0, 18'h3C402, 32'h0, 4'hF);
    check("misaligned", er, 96'h1);
    $display("test refusals done");
    summarize();
  end
endmodule : tb_pgsel_top
